// [rtl/aaie_pkg.sv]
// Package: constants, offsets and types of the add/AND execute block
package aaie_pkg;

   // ----------------------------------------------------------------
   // Instruction cycle
   // ----------------------------------------------------------------
   localparam int unsigned PHASES = 4;         // Clock periods per cycle
   localparam logic [1:0]  PHASE_READ = 2'h0;  // File operand read issued
   localparam logic [1:0]  PHASE_GRAB = 2'h1;  // File operand captured
   localparam logic [1:0]  PHASE_LAST = 2'h3;  // Write-back, cycle end

   // ----------------------------------------------------------------
   // Opcode patterns (14-bit words)
   // ----------------------------------------------------------------
   localparam logic [4:0] PAT_ADD_LIT  = 5'h1f;  // 11 111x
   localparam logic [5:0] PAT_AND_LIT  = 6'h39;  // 11 1001
   localparam logic [5:0] PAT_ADD_FILE = 6'h07;  // 00 0111
   localparam logic [5:0] PAT_AND_FILE = 6'h05;  // 00 0101
   localparam int unsigned DEST_BIT    = 7;      // Destination select

   // ----------------------------------------------------------------
   // Special file addresses
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_TIMER = 7'h01;  // Timer zero count
   localparam logic [6:0] ADDR_PCL   = 7'h02;  // Program counter low
   localparam logic [6:0] ADDR_PORT  = 7'h06;  // I/O port

   // ----------------------------------------------------------------
   // APB register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_INSTR  = 12'h000;
   localparam logic [11:0] OFS_WORK   = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_CTRL   = 12'h00c;
   localparam logic [11:0] OFS_PRESC  = 12'h010;
   localparam logic [11:0] OFS_PINS   = 12'h014;
   localparam logic [11:0] OFS_FILE   = 12'h400;  // 128 words follow
   localparam logic [1:0]  FILE_SEL   = 2'h1;     // PADDR[11:10]

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [13:0] RST_INSTR = 14'h0000;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      AAIE_IDLE = 3'b001,   // Waiting for an instruction
      AAIE_EXEC = 3'b010,   // Executing one instruction cycle
      AAIE_NOPC = 3'b100    // Second cycle, no_operation
   } aaie_state_type;

   typedef enum logic [2:0] {
      OP_NONE     = 3'h0,
      OP_ADD_LIT  = 3'h1,
      OP_AND_LIT  = 3'h2,
      OP_ADD_FILE = 3'h3,
      OP_AND_FILE = 3'h4
   } aaie_op_type;

endpackage

// [rtl/aaie_phase_div.sv]
// Phase divider: four clock periods make one instruction cycle
`timescale 1ns/1ps
`default_nettype none

module aaie_phase_div (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Phase outputs
   output logic [1:0]      phase,
   output logic            cycle_end
);

   typedef struct packed {
      logic [1:0] q;        // Current phase
   } aaie_div_type;

   aaie_div_type s_reg;     // Registered state
   aaie_div_type s_next;    // Next state

   // Wrap-around phase count
   always_comb begin
      s_next   = s_reg;
      s_next.q = 2'(s_reg.q + 2'h1);
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign phase     = s_reg.q;
   assign cycle_end = (s_reg.q == aaie_pkg::PHASE_LAST);

endmodule

`default_nettype wire

// [rtl/aaie_file_mem.sv]
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module aaie_file_mem #(
   parameter int unsigned AW = 7,   // Address width
   parameter int unsigned DW = 8    // Data width
) (
   // Clock
   input  wire logic          clk,
   // Access port
   input  wire logic          en,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic [DW-1:0]      rdata
);

   logic [DW-1:0] mem [2**AW];   // Storage, no reset (plain RAM)
   logic [DW-1:0] rdata_reg;     // Read data register

   // Single port, read-first
   always_ff @(posedge clk) begin
      if (en) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata_reg <= mem[addr];
      end
   end

   assign rdata = rdata_reg;

endmodule

`default_nettype wire

// [rtl/aaie_core.sv]
// Add/AND instruction execute block with APB register access
`timescale 1ns/1ps
`default_nettype none

// Function
// - Port read-modify-write uses pin levels
// - Timer zero write clears assigned prescaler
// - Program counter change costs second cycle
// - Add literal to working register, C DC Z
// - AND literal into working register, Z only
// - Add file to working register, C DC Z
// - Destination bit selects working or file
// - AND file with working register, Z only
// - Instruction cycle is four clock periods
module aaie_core (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        NRST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // I/O port
   input  wire logic [7:0]  PIN_IN,
   output logic [7:0]       PORT_OUT
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      aaie_pkg::aaie_state_type st;  // Execute sequencer
      logic        pend;             // Instruction waiting
      logic [13:0] instr;            // Instruction word
      logic [7:0]  w;                // Working register
      logic        c;                // Carry
      logic        dc;               // digit_carry_flag
      logic        z;                // Zero
      logic        ill;              // Unknown opcode seen
      logic [7:0]  opnd;             // Captured file operand
      logic [7:0]  port;             // Port output latch
      logic        psa;              // Prescaler on timer zero
      logic        pen;              // Prescaler count enable
      logic [7:0]  presc;            // Prescaler count
      logic        issued;           // APB file access started
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } aaie_core_type;

   aaie_core_type s_reg;   // Registered state
   aaie_core_type s_next;  // Next state

   logic [1:0]  phase;     // Phase inside the instruction cycle
   logic        cyc_end;   // Last phase of a cycle
   logic        mem_en;    // Memory strobe
   logic        mem_we;    // Memory write
   logic [6:0]  mem_addr;  // Memory address
   logic [7:0]  mem_wd;    // Memory write data
   logic [7:0]  mem_rd;    // Memory read data
   aaie_pkg::aaie_op_type kind;  // Decoded operation
   logic        is_file;   // File-register form
   logic        dest_f;    // Result goes to the file
   logic [6:0]  f_addr;    // File address field
   logic [7:0]  operand;   // Second ALU operand
   logic [9:0]  sum;       // {carry, digit carry, sum}
   logic [7:0]  res;       // Result byte
   logic        wb;        // Write-back phase
   logic        busy;      // Instruction in flight

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Opcode decode; anything else is OP_NONE, which only raises the illegal bit
   function automatic aaie_pkg::aaie_op_type decode(input logic [13:0] i);
      aaie_pkg::aaie_op_type k;
      k = aaie_pkg::OP_NONE;
      if (i[13:9] == aaie_pkg::PAT_ADD_LIT) begin
         k = aaie_pkg::OP_ADD_LIT;
      end else if (i[13:8] == aaie_pkg::PAT_AND_LIT) begin
         k = aaie_pkg::OP_AND_LIT;
      end else if (i[13:8] == aaie_pkg::PAT_ADD_FILE) begin
         k = aaie_pkg::OP_ADD_FILE;
      end else if (i[13:8] == aaie_pkg::PAT_AND_FILE) begin
         k = aaie_pkg::OP_AND_FILE;
      end
      return k;
   endfunction

   // Add with carry out of bit 7 and bit 3
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
      logic [4:0] lo;
      logic [8:0] t;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      t  = {1'b0, a} + {1'b0, b};
      return {t[8], lo[4], t[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // Sub-blocks
   // ----------------------------------------------------------------
   aaie_phase_div u_div (
      .clk       (CLK),
      .nrst      (NRST),
      .phase     (phase),
      .cycle_end (cyc_end)
   );

   aaie_file_mem #(.AW(7), .DW(8)) u_mem (
      .clk   (CLK),
      .en    (mem_en),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (mem_wd),
      .rdata (mem_rd)
   );

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------
   // Literal forms take the low byte, file forms the captured operand
   always_comb begin
      kind    = decode(s_reg.instr);
      is_file = (kind == aaie_pkg::OP_ADD_FILE) || (kind == aaie_pkg::OP_AND_FILE);
      dest_f  = is_file && s_reg.instr[aaie_pkg::DEST_BIT];
      f_addr  = s_reg.instr[6:0];
      operand = is_file ? s_reg.opnd : s_reg.instr[7:0];
      sum     = add8(s_reg.w, operand);
      if ((kind == aaie_pkg::OP_ADD_LIT) || (kind == aaie_pkg::OP_ADD_FILE)) begin
         res = sum[7:0];
      end else begin
         res = s_reg.w & operand;
      end
      wb   = (s_reg.st == aaie_pkg::AAIE_EXEC) && (phase == aaie_pkg::PHASE_LAST);
      busy = s_reg.pend || (s_reg.st != aaie_pkg::AAIE_IDLE);
   end

   // ----------------------------------------------------------------
   // Next state: APB first, execution after so hardware wins
   // ----------------------------------------------------------------
   always_comb begin
      s_next   = s_reg;
      mem_en   = 1'b0;
      mem_we   = 1'b0;
      mem_addr = PADDR[8:2];
      mem_wd   = PWDATA[7:0];
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;

      // Prescaler ticks once per instruction cycle
      if (cyc_end && s_reg.pen) begin
         s_next.presc = 8'(s_reg.presc + 8'h01);
      end

      // APB access phase; registers answer one cycle later, the file window two or more
      if (PSEL && PENABLE && !s_reg.pready) begin
         if (PADDR[11:10] == aaie_pkg::FILE_SEL && PADDR[9] == 1'b0) begin
            // File window shares the RAM; only while the sequencer rests
            if (!s_reg.issued) begin
               if (s_reg.st == aaie_pkg::AAIE_IDLE) begin
                  mem_en        = 1'b1;
                  mem_we        = PWRITE;
                  s_next.issued = 1'b1;
                  if (PWRITE && PADDR[8:2] == aaie_pkg::ADDR_PORT) begin
                     s_next.port = PWDATA[7:0];
                  end
               end
            end else begin
               s_next.issued = 1'b0;
               s_next.pready = 1'b1;
               s_next.prdata = PWRITE ? aaie_pkg::RST_WORD : {24'h0, mem_rd};
            end
         end else begin
            s_next.pready = 1'b1;
            s_next.prdata = aaie_pkg::RST_WORD;
            unique case (PADDR)
               aaie_pkg::OFS_INSTR: begin
                  s_next.prdata = {18'h0, s_reg.instr};
                  if (PWRITE) begin
                     // New word refused while one is in flight
                     if (busy) begin
                        s_next.pslverr = 1'b1;
                     end else begin
                        s_next.instr = PWDATA[13:0];
                        s_next.pend  = 1'b1;
                     end
                  end
               end
               aaie_pkg::OFS_WORK: begin
                  s_next.prdata = {24'h0, s_reg.w};
                  if (PWRITE) begin
                     if (busy) begin
                        s_next.pslverr = 1'b1;
                     end else begin
                        s_next.w = PWDATA[7:0];
                     end
                  end
               end
               aaie_pkg::OFS_STATUS: begin
                  s_next.prdata = {27'h0, s_reg.ill, busy, s_reg.z, s_reg.dc, s_reg.c};
                  if (PWRITE) begin
                     if (busy) begin
                        s_next.pslverr = 1'b1;
                     end else begin
                        s_next.c  = PWDATA[0];
                        s_next.dc = PWDATA[1];
                        s_next.z  = PWDATA[2];
                        if (PWDATA[4]) begin
                           s_next.ill = 1'b0;  // Write one to clear
                        end
                     end
                  end
               end
               aaie_pkg::OFS_CTRL: begin
                  s_next.prdata = {30'h0, s_reg.pen, s_reg.psa};
                  if (PWRITE) begin
                     s_next.psa = PWDATA[0];
                     s_next.pen = PWDATA[1];
                  end
               end
               aaie_pkg::OFS_PRESC: begin
                  s_next.prdata = {24'h0, s_reg.presc};
               end
               aaie_pkg::OFS_PINS: begin
                  s_next.prdata = {16'h0, s_reg.port, PIN_IN};
               end
               default: begin
                  s_next.pslverr = 1'b1;  // Unmapped address
               end
            endcase
         end
      end

      // Execution sequencer, aligned to instruction cycles
      unique case (s_reg.st)
         aaie_pkg::AAIE_IDLE: begin
            if (s_reg.pend && cyc_end) begin
               s_next.pend = 1'b0;
               s_next.st   = aaie_pkg::AAIE_EXEC;
            end
         end
         aaie_pkg::AAIE_EXEC: begin
            if (phase == aaie_pkg::PHASE_READ && is_file) begin
               mem_en   = 1'b1;
               mem_we   = 1'b0;
               mem_addr = f_addr;
            end
            if (phase == aaie_pkg::PHASE_GRAB) begin
               // Port reads see the pins, not the latch
               s_next.opnd = (f_addr == aaie_pkg::ADDR_PORT) ? PIN_IN : mem_rd;
            end
            if (wb) begin
               s_next.st = aaie_pkg::AAIE_IDLE;
               if (kind == aaie_pkg::OP_NONE) begin
                  s_next.ill = 1'b1;
               end else begin
                  s_next.z = (res == 8'h00);
                  if ((kind == aaie_pkg::OP_ADD_LIT) || (kind == aaie_pkg::OP_ADD_FILE)) begin
                     s_next.c  = sum[9];
                     s_next.dc = sum[8];
                  end
                  if (dest_f) begin
                     mem_en   = 1'b1;
                     mem_we   = 1'b1;
                     mem_addr = f_addr;
                     mem_wd   = res;
                     if (f_addr == aaie_pkg::ADDR_PORT) begin
                        s_next.port = res;
                     end
                     if (f_addr == aaie_pkg::ADDR_TIMER && s_reg.psa) begin
                        s_next.presc = aaie_pkg::RST_BYTE;
                     end
                     if (f_addr == aaie_pkg::ADDR_PCL) begin
                        s_next.st = aaie_pkg::AAIE_NOPC;
                     end
                  end else begin
                     s_next.w = res;
                  end
               end
            end
         end
         aaie_pkg::AAIE_NOPC: begin
            // Whole second cycle does nothing
            if (cyc_end) begin
               s_next.st = aaie_pkg::AAIE_IDLE;
            end
         end
         default: begin
            s_next.st = aaie_pkg::AAIE_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_reg        <= '0;
         s_reg.st     <= aaie_pkg::AAIE_IDLE;
         s_reg.instr  <= aaie_pkg::RST_INSTR;
         s_reg.prdata <= aaie_pkg::RST_WORD;
      end else begin
         s_reg <= s_next;
      end
   end

   assign PRDATA   = s_reg.prdata;
   assign PREADY   = s_reg.pready;
   assign PSLVERR  = s_reg.pslverr;
   assign PORT_OUT = s_reg.port;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   pin_capture_a: assert property ((s_reg.st == aaie_pkg::AAIE_EXEC) && (phase == aaie_pkg::PHASE_GRAB) && is_file && (f_addr == aaie_pkg::ADDR_PORT) |=> s_reg.opnd == $past(PIN_IN)) else $error("port operand not from pins");
   presc_clear_a: assert property (wb && dest_f && (f_addr == aaie_pkg::ADDR_TIMER) && s_reg.psa |=> s_reg.presc == 8'h00) else $error("prescaler not cleared");
   pc_second_a: assert property (wb && dest_f && (f_addr == aaie_pkg::ADDR_PCL) |=> (s_reg.st == aaie_pkg::AAIE_NOPC)[*4] ##1 (s_reg.st == aaie_pkg::AAIE_IDLE)) else $error("no second cycle");
   add_literal_a: assert property (wb && (kind == aaie_pkg::OP_ADD_LIT) |=> s_reg.w == 8'($past(s_reg.w) + $past(s_reg.instr[7:0]))) else $error("add literal wrong");
   and_literal_a: assert property (wb && (kind == aaie_pkg::OP_AND_LIT) |=> (s_reg.w == ($past(s_reg.w) & $past(s_reg.instr[7:0]))) && $stable(s_reg.c) && $stable(s_reg.dc)) else $error("and literal wrong");
   add_file_a: assert property (wb && (kind == aaie_pkg::OP_ADD_FILE) && !dest_f |=> s_reg.w == 8'($past(s_reg.w) + $past(s_reg.opnd))) else $error("add file wrong");
   dest_file_a: assert property (wb && dest_f |-> mem_we && (mem_wd == res) ##1 $stable(s_reg.w)) else $error("destination wrong");
   and_file_a: assert property (wb && (kind == aaie_pkg::OP_AND_FILE) && !dest_f |=> (s_reg.w == ($past(s_reg.w) & $past(s_reg.opnd))) && $stable(s_reg.c)) else $error("and file wrong");
   cycle_len_a: assert property (cyc_end |=> !cyc_end [*3] ##1 cyc_end) else $error("cycle not four clocks");
   zero_flag_a: assert property (wb && (kind != aaie_pkg::OP_NONE) |=> s_reg.z == ($past(res) == 8'h00)) else $error("zero flag wrong");
   exec_start_a: assert property (s_reg.pend && cyc_end && (s_reg.st == aaie_pkg::AAIE_IDLE) |=> (s_reg.st == aaie_pkg::AAIE_EXEC) ##3 wb) else $error("execute not one cycle");

   add_carry_c: cover property (wb && (kind == aaie_pkg::OP_ADD_LIT) && sum[9]);
   file_dest_c: cover property (wb && (kind == aaie_pkg::OP_AND_FILE) && dest_f);
   port_rmw_c:  cover property (wb && dest_f && (f_addr == aaie_pkg::ADDR_PORT));
   pc_nop_c:    cover property (s_reg.st == aaie_pkg::AAIE_NOPC);

endmodule

`default_nettype wire

// [verification/aaie_core_tb.sv]
// Self-checking testbench of the add/AND execute block
`timescale 1ns/1ps
`default_nettype none

module aaie_core_tb;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk, nrst, psel, penable, pwrite;  // Clock, reset, APB control
   logic [11:0] paddr;                             // APB address
   logic [31:0] pwdata, prdata, rd, p;             // Bus data, captured data
   logic        pready, pslverr, err;              // Answer and captured error
   logic [7:0]  pin_in, port_out;                  // I/O port
   int          num_errors, n_checks, cyc, d_norm, d_pc, t0;

   aaie_core u_aaie_core (
      .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PIN_IN(pin_in), .PORT_OUT(port_out)
   );

   // Free clock and a cycle count for timing checks
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Verdict and end of run, also reached by any timeout
   task complete_run;
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; PREADY and the answer are taken at the rising edge itself,
   // before that edge's register updates land, then the request is released
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         num_errors++;
         $display("Error at %0t: bus answer timeout", $time);
         complete_run();
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Poll busy until it drops; cycles since start returned
   task automatic wait_idle(input int start, output int d);
      int n;
      n = 0;
      do begin
         apb(1'b0, aaie_pkg::OFS_STATUS, 32'h0);
         n++;
      end while (rd[3] !== 1'b0 && n < 20);
      if (rd[3] !== 1'b0) begin
         num_errors++;
         $display("Error at %0t: busy never dropped", $time);
         complete_run();
      end
      d = cyc - start;
   endtask

   task automatic run(input logic [13:0] ins, output int d);
      apb(1'b1, aaie_pkg::OFS_INSTR, {18'h0, ins});
      t0 = cyc;
      wait_idle(t0, d);
   endtask

   // Busy read at the edge nine clocks after the instruction is taken:
   // a plain cycle has ended by then, a program counter write has not
   task automatic probe(input logic [13:0] ins, input logic bexp);
      int d;
      apb(1'b1, aaie_pkg::OFS_INSTR, {18'h0, ins});
      repeat (5) @(posedge clk);
      apb(1'b0, aaie_pkg::OFS_STATUS, 32'h0);
      chk({31'h0, rd[3]}, {31'h0, bexp});
      wait_idle(cyc, d);
   endtask

   function automatic logic [11:0] fa(input logic [6:0] f);
      return aaie_pkg::OFS_FILE + {3'h0, f, 2'h0};
   endfunction

   // Preload W and flags, execute, compare W and the status low bits
   task automatic ex(input logic [13:0] ins, input logic [7:0] w0, input logic [4:0] s0,
                     input logic [7:0] wexp, input logic [4:0] sexp);
      int d;
      apb(1'b1, aaie_pkg::OFS_WORK, {24'h0, w0});
      apb(1'b1, aaie_pkg::OFS_STATUS, {27'h0, s0});
      run(ins, d);
      apb(1'b0, aaie_pkg::OFS_WORK, 32'h0);
      chk(rd, {24'h0, wexp});
      apb(1'b0, aaie_pkg::OFS_STATUS, 32'h0);
      chk(rd, {27'h0, sexp});
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      cyc = 0; num_errors = 0; n_checks = 0;
      nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; pin_in = 8'h0f;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      // Reset values, then an unmapped address
      apb(1'b0, aaie_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk({24'h0, port_out}, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // Literal forms, including carry out of both nibbles
      ex(14'h3e15, 8'h10, 5'h00, 8'h25, 5'h00);
      ex(14'h3f01, 8'hff, 5'h00, 8'h00, 5'h07);
      ex(14'h3e08, 8'h08, 5'h00, 8'h10, 5'h02);
      ex(14'h395f, 8'ha3, 5'h03, 8'h03, 5'h03);
      ex(14'h3900, 8'hff, 5'h00, 8'h00, 5'h04);
      // File forms with both destinations
      apb(1'b1, fa(7'h20), 32'hc2);
      ex(14'h0720, 8'h17, 5'h00, 8'hd9, 5'h00);
      apb(1'b0, fa(7'h20), 32'h0);
      chk(rd, 32'hc2);
      ex(14'h07a0, 8'h40, 5'h00, 8'h40, 5'h01);
      apb(1'b0, fa(7'h20), 32'h0);
      chk(rd, 32'h02);
      ex(14'h05a0, 8'h03, 5'h03, 8'h03, 5'h03);
      ex(14'h0520, 8'h01, 5'h00, 8'h00, 5'h04);
      // Port rewrite must take pin levels, not the latch
      apb(1'b1, fa(aaie_pkg::ADDR_PORT), 32'hff);
      ex(14'h0586, 8'hff, 5'h00, 8'hff, 5'h00);
      apb(1'b0, fa(aaie_pkg::ADDR_PORT), 32'h0);
      chk(rd, 32'h0f);
      chk({24'h0, port_out}, 32'h0f);
      apb(1'b0, aaie_pkg::OFS_PINS, 32'h0);
      chk(rd, 32'h0f0f);
      // Prescaler clear only for d=1 while assigned to the timer
      apb(1'b1, fa(aaie_pkg::ADDR_TIMER), 32'h0);
      apb(1'b1, aaie_pkg::OFS_CTRL, 32'h3);
      repeat (40) @(posedge clk);
      apb(1'b1, aaie_pkg::OFS_CTRL, 32'h1);
      apb(1'b0, aaie_pkg::OFS_PRESC, 32'h0);
      p = rd;
      chk({31'h0, p == 32'h0}, 32'h0);
      run(14'h0701, d_norm);
      apb(1'b0, aaie_pkg::OFS_PRESC, 32'h0);
      chk(rd, p);
      run(14'h0781, d_norm);
      apb(1'b0, aaie_pkg::OFS_PRESC, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, aaie_pkg::OFS_CTRL, 32'h2);
      repeat (40) @(posedge clk);
      apb(1'b1, aaie_pkg::OFS_CTRL, 32'h0);
      apb(1'b0, aaie_pkg::OFS_PRESC, 32'h0);
      p = rd;
      run(14'h0781, d_norm);
      apb(1'b0, aaie_pkg::OFS_PRESC, 32'h0);
      chk(rd, p);
      // One cycle normally, a second one when the program counter is written
      run(14'h3e01, d_norm);
      chk({31'h0, d_norm >= 5 && d_norm <= 12}, 32'h1);
      apb(1'b1, fa(aaie_pkg::ADDR_PCL), 32'h0);
      run(14'h0782, d_pc);
      chk({31'h0, d_pc >= 9}, 32'h1);
      probe(14'h3e01, 1'b0);
      probe(14'h0782, 1'b1);
      // A write while busy is refused and leaves W alone
      apb(1'b1, aaie_pkg::OFS_WORK, 32'h30);
      apb(1'b1, aaie_pkg::OFS_INSTR, 32'h3e01);
      t0 = cyc;
      apb(1'b1, aaie_pkg::OFS_WORK, 32'h99);
      chk({31'h0, err}, 32'h1);
      wait_idle(t0, d_norm);
      apb(1'b0, aaie_pkg::OFS_WORK, 32'h0);
      chk(rd, 32'h31);
      // Unknown opcode keeps flags and raises the illegal bit
      ex(14'h3400, 8'h55, 5'h03, 8'h55, 5'h13);
      apb(1'b1, aaie_pkg::OFS_STATUS, 32'h10);
      apb(1'b0, aaie_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      complete_run();
   end
endmodule

`default_nettype wire
